//--- banked_io_defs.svh
// Offsets, reset values, masks and bit positions of the banked register space
`ifndef BANKED_IO_DEFS_SVH
`define BANKED_IO_DEFS_SVH
// Size of the whole register space in bytes, two banks of equal size
`define BIO_SPACE_BYTES 512
`define BIO_BANK_BYTES 256
// Register indices within a bank, byte address is four times the index
`define BIO_OFF_P0_DATA 8'h00
`define BIO_OFF_P0_IE 8'h01
`define BIO_OFF_P0_GS 8'h02
`define BIO_OFF_P0_DM2 8'h03
`define BIO_OFF_P1_DATA 8'h04
`define BIO_OFF_P1_IE 8'h05
`define BIO_OFF_P1_GS 8'h06
`define BIO_OFF_P1_DM2 8'h07
`define BIO_OFF_ASC_A 8'h80
`define BIO_OFF_ASC_B 8'h84
`define BIO_OFF_FLAG 8'hF7
`define BIO_OFF_CFG 8'hF8
`define BIO_OFF_STATUS 8'hF9
// Reset values
`define BIO_RST_ZERO 8'h00
`define BIO_RST_DM2_ALL_HIZ 8'hFF
`define BIO_RST_P1_DM2 8'hFC
// Writable bits per register
`define BIO_WM_FULL 8'hFF
`define BIO_WM_FLAG 8'h01
`define BIO_WM_CFG 8'h01
`define BIO_CM_STATUS 8'h01
// Bit positions
`define BIO_FLAG_BANK_BIT 0
`define BIO_CFG_OPTIONAL_EXTERNAL_CLOCK_BIT 0
`define BIO_STATUS_RSVD_BIT 0
`define BIO_OPTIONAL_EXTERNAL_CLOCK_PIN 4
// Table indices of the bit-pattern registers
`define BIO_IDX_P0_DATA 0
`define BIO_IDX_P0_DM2 3
`define BIO_IDX_P1_DATA 4
`define BIO_IDX_P1_DM2 7
`define BIO_IDX_ASC_A 8
`define BIO_IDX_ASC_B 9
`define BIO_IDX_FLAG 10
`define BIO_IDX_CFG 11
`endif

//--- banked_io_pkg.sv
// Types shared by the banked register space
`default_nettype none
package banked_io_pkg;
   // Level and active-low enable of one 8-pin port
   typedef struct packed {
      logic [7:0] level;
      logic [7:0] oe_n;
   } pin_drive_t;
   // Bank reached by an access
   typedef enum logic [0:0] {
      BANK_ZERO = 1'b0,
      BANK_ONE = 1'b1
   } bank_t;
   // Bus slave phase
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } bus_state_t;
endpackage
`default_nettype wire

//--- banked_io_register_space.sv
// Banked byte register space behind a classic Wishbone slave
`include "banked_io_defs.svh"
`default_nettype none
module banked_io_register_space #(
   parameter int SPACE_BYTES = `BIO_SPACE_BYTES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [9:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic external_reset_input_i,
   input wire logic [7:0] port0_pins_i,
   input wire logic [7:0] port1_pins_i,
   output banked_io_pkg::pin_drive_t port0_pins_o,
   output banked_io_pkg::pin_drive_t port1_pins_o,
   output logic [7:0] analog_sc_block_a_ctrl_o,
   output logic [7:0] analog_sc_block_b_ctrl_o,
   output logic bank_select_flag_o,
   output logic optional_external_clock_sel_o,
   output logic optional_external_clock_o
);
   import banked_io_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Register table

   localparam int REG_COUNT = 12;
   // Index offsets, one per stored register
   localparam logic [7:0] REG_OFF [REG_COUNT] = '{
      `BIO_OFF_P0_DATA, `BIO_OFF_P0_IE, `BIO_OFF_P0_GS, `BIO_OFF_P0_DM2,
      `BIO_OFF_P1_DATA, `BIO_OFF_P1_IE, `BIO_OFF_P1_GS, `BIO_OFF_P1_DM2,
      `BIO_OFF_ASC_A, `BIO_OFF_ASC_B, `BIO_OFF_FLAG, `BIO_OFF_CFG};
   // Reset values; port 1 low pins come up driven
   localparam logic [7:0] REG_RST [REG_COUNT] = '{
      `BIO_RST_ZERO, `BIO_RST_ZERO, `BIO_RST_ZERO, `BIO_RST_DM2_ALL_HIZ,
      `BIO_RST_ZERO, `BIO_RST_ZERO, `BIO_RST_ZERO, `BIO_RST_P1_DM2,
      `BIO_RST_ZERO, `BIO_RST_ZERO, `BIO_RST_ZERO, `BIO_RST_ZERO};
   // Writable bits; others read back as stored reset value
   localparam logic [7:0] REG_WM [REG_COUNT] = '{
      `BIO_WM_FULL, `BIO_WM_FULL, `BIO_WM_FULL, `BIO_WM_FULL,
      `BIO_WM_FULL, `BIO_WM_FULL, `BIO_WM_FULL, `BIO_WM_FULL,
      `BIO_WM_FULL, `BIO_WM_FULL, `BIO_WM_FLAG, `BIO_WM_CFG};
   // Reached from both banks (flag and config only)
   localparam logic [REG_COUNT-1:0] REG_BOTH = 12'hC00;

   // Refuse a space the decoder cannot serve
   if (SPACE_BYTES != `BIO_SPACE_BYTES) begin : g_space_check
      $error("register space must be 512 bytes");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [7:0] regs [REG_COUNT]; // Stored registers
   logic [7:0] status; // Sticky event bits
   logic ext_meta; // External reset, first stage
   logic ext_sync; // External reset, synchronised
   logic soft_rst; // Either reset source
   bus_state_t state; // Bus phase
   bank_t bank; // Bank of the current access
   logic [7:0] off; // Index within the bank
   logic req; // New request in idle phase
   logic hit_valid; // Offset maps to a stored register
   logic [3:0] hit_idx; // Which stored register
   logic hit_status; // Offset maps to status
   logic wr_commit; // Write takes effect now
   logic [7:0] next_read; // Byte returned for the request
   logic [7:0] p0_data_view; // Port 0 data as software sees it
   logic [7:0] p1_data_view; // Port 1 data as software sees it

   assign bank = bank_t'(regs[`BIO_IDX_FLAG][`BIO_FLAG_BANK_BIT]);
   assign off = adr_i[9:2];
   assign req = cyc_i && stb_i && (state == BUS_IDLE);
   // Commit at the edge where the master samples ack
   assign wr_commit = cyc_i && stb_i && we_i && (state == BUS_ACK) && sel_i[0];
   assign soft_rst = rst_i || ext_sync;

   ////////////////////////////////////////////////////////////////////////////
   // External reset pin

   // Two-stage synchroniser; pin idles low so floating means run
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
      end else begin
         ext_meta <= external_reset_input_i;
         ext_sync <= ext_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   // Bank 0 holds ports and analog; bank 1 is blank except shared registers
   always_comb begin
      hit_valid = 1'b0;
      hit_idx = 4'h0;
      for (int i = 0; i < REG_COUNT; i++) begin
         if (off == REG_OFF[i] && (REG_BOTH[i] || bank == BANK_ZERO)) begin
            hit_valid = 1'b1;
            hit_idx = 4'(i);
         end
      end
   end

   assign hit_status = (off == `BIO_OFF_STATUS);

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   // Input pins show the pin level, driven pins the latched value
   assign p0_data_view = (port0_pins_i & regs[`BIO_IDX_P0_DM2])
      | (regs[`BIO_IDX_P0_DATA] & ~regs[`BIO_IDX_P0_DM2]);
   assign p1_data_view = (port1_pins_i & regs[`BIO_IDX_P1_DM2])
      | (regs[`BIO_IDX_P1_DATA] & ~regs[`BIO_IDX_P1_DM2]);

   // Blank locations read as zero
   always_comb begin
      next_read = 8'h00;
      if (hit_valid) begin
         unique case (hit_idx)
            4'(`BIO_IDX_P0_DATA): next_read = p0_data_view;
            4'(`BIO_IDX_P1_DATA): next_read = p1_data_view;
            default: next_read = regs[hit_idx];
         endcase
      end else if (hit_status) begin
         next_read = status;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave

   // Ack one cycle after the request, dropped the next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= BUS_IDLE;
         ack_o <= 1'b0;
      end else begin
         unique case (state)
            BUS_IDLE: begin
               if (cyc_i && stb_i) begin
                  state <= BUS_ACK;
                  ack_o <= 1'b1;
               end
            end
            BUS_ACK: begin
               state <= BUS_IDLE;
               ack_o <= 1'b0;
            end
         endcase
      end
   end

   // Read data captured with the request; upper lanes read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (req) begin
         dat_o <= {24'h00_0000, we_i ? 8'h00 : next_read};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register storage

   // One update process per register; only writable bits change
   for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
      always_ff @(posedge clk_i) begin
         if (soft_rst) begin
            regs[g] <= REG_RST[g];
         end else if (wr_commit && hit_valid && hit_idx == 4'(g)) begin
            regs[g] <= (regs[g] & ~REG_WM[g]) | (dat_i[7:0] & REG_WM[g]);
         end
      end
   end

   // Blank access is logged; writing 1 clears, a new event wins
   always_ff @(posedge clk_i) begin
      if (soft_rst) begin
         status <= `BIO_RST_ZERO;
      end else begin
         if (cyc_i && stb_i && state == BUS_ACK && !hit_valid && !hit_status) begin
            status[`BIO_STATUS_RSVD_BIT] <= 1'b1;
         end else if (wr_commit && hit_status) begin
            status <= status & ~(dat_i[7:0] & `BIO_CM_STATUS);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pins and block outputs

   // Registered pin drive; programming pins stay driven in reset
   always_ff @(posedge clk_i) begin
      if (soft_rst) begin
         port0_pins_o <= '{level: `BIO_RST_ZERO, oe_n: `BIO_RST_DM2_ALL_HIZ};
         port1_pins_o <= '{level: `BIO_RST_ZERO, oe_n: `BIO_RST_P1_DM2};
      end else begin
         port0_pins_o <= '{level: regs[`BIO_IDX_P0_DATA], oe_n: regs[`BIO_IDX_P0_DM2]};
         port1_pins_o.level <= regs[`BIO_IDX_P1_DATA];
         port1_pins_o.oe_n <= regs[`BIO_IDX_P1_DM2];
         // Clock pin must not fight the external source
         if (regs[`BIO_IDX_CFG][`BIO_CFG_OPTIONAL_EXTERNAL_CLOCK_BIT]) begin
            port1_pins_o.oe_n[`BIO_OPTIONAL_EXTERNAL_CLOCK_PIN] <= 1'b1;
         end
      end
   end

   // Analog controls, bank flag and clock source selection
   always_ff @(posedge clk_i) begin
      if (soft_rst) begin
         analog_sc_block_a_ctrl_o <= `BIO_RST_ZERO;
         analog_sc_block_b_ctrl_o <= `BIO_RST_ZERO;
         bank_select_flag_o <= 1'b0;
         optional_external_clock_sel_o <= 1'b0;
         optional_external_clock_o <= 1'b0;
      end else begin
         analog_sc_block_a_ctrl_o <= regs[`BIO_IDX_ASC_A];
         analog_sc_block_b_ctrl_o <= regs[`BIO_IDX_ASC_B];
         bank_select_flag_o <= regs[`BIO_IDX_FLAG][`BIO_FLAG_BANK_BIT];
         optional_external_clock_sel_o <= regs[`BIO_IDX_CFG][`BIO_CFG_OPTIONAL_EXTERNAL_CLOCK_BIT];
         // Gated copy of pin 4, low while the internal source is used
         optional_external_clock_o <= regs[`BIO_IDX_CFG][`BIO_CFG_OPTIONAL_EXTERNAL_CLOCK_BIT]
            & port1_pins_i[`BIO_OPTIONAL_EXTERNAL_CLOCK_PIN];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   AST_BANK0_ANALOG: assert property (
      @(posedge clk_i) disable iff (soft_rst)
      (req && !we_i && bank == BANK_ZERO && off == `BIO_OFF_ASC_A)
      |=> (ack_o && dat_o[7:0] == $past(regs[`BIO_IDX_ASC_A])))
      else $error("bank 0 analog read returned wrong byte");

   AST_BANK1_BLANK: assert property (
      @(posedge clk_i) disable iff (soft_rst)
      (req && !we_i && bank == BANK_ONE && off == `BIO_OFF_ASC_A)
      |=> (dat_o == 32'h0000_0000))
      else $error("bank 1 access reached a bank 0 register");

   AST_PORT1_WRITE: assert property (
      @(posedge clk_i) disable iff (soft_rst)
      (wr_commit && bank == BANK_ZERO && off == `BIO_OFF_P1_DATA)
      |=> (regs[`BIO_IDX_P1_DATA] == $past(dat_i[7:0])))
      else $error("port 1 data write not stored");

   AST_STATUS_STICKY: assert property (
      @(posedge clk_i) disable iff (soft_rst)
      (status[`BIO_STATUS_RSVD_BIT] && !(wr_commit && hit_status && dat_i[0]))
      |=> status[`BIO_STATUS_RSVD_BIT])
      else $error("clearable status bit lost without a clear");

   AST_EXT_RESET: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ext_sync |=> (regs[`BIO_IDX_FLAG] == `BIO_RST_ZERO && status == `BIO_RST_ZERO))
      else $error("external reset did not clear registers");

   AST_PROG_PINS_DRIVEN: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> (port1_pins_o.oe_n[1:0] == 2'b00))
      else $error("programming pins released during reset");

   AST_EXT_CLOCK: assert property (
      @(posedge clk_i) disable iff (soft_rst)
      (regs[`BIO_IDX_CFG][`BIO_CFG_OPTIONAL_EXTERNAL_CLOCK_BIT] ##1 !soft_rst)
      |-> (port1_pins_o.oe_n[`BIO_OPTIONAL_EXTERNAL_CLOCK_PIN]
         && optional_external_clock_o == $past(port1_pins_i[`BIO_OPTIONAL_EXTERNAL_CLOCK_PIN])))
      else $error("external clock pin not routed");

   AST_NO_WAIT: assert property (
      @(posedge clk_i) disable iff (soft_rst)
      req |=> ack_o ##1 !ack_o)
      else $error("access not acknowledged in one cycle");

   AST_BLANK_LOGGED: assert property (
      @(posedge clk_i) disable iff (soft_rst)
      (cyc_i && stb_i && state == BUS_ACK && !hit_valid && !hit_status)
      |=> status[`BIO_STATUS_RSVD_BIT])
      else $error("blank location access not logged");

   AST_PORT0_PINS: assert property (
      @(posedge clk_i) disable iff (soft_rst)
      1'b1 |=> (port0_pins_o.level == $past(regs[`BIO_IDX_P0_DATA])
         && port0_pins_o.oe_n == $past(regs[`BIO_IDX_P0_DM2])))
      else $error("port 0 pins do not follow their registers");

endmodule // banked_io_register_space
`default_nettype wire

//--- bus_master_model.sv
// Processor core side: classic Wishbone single-cycle byte master
`default_nettype none
module bus_master_model (
   input wire logic clk_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [9:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o,
   input wire logic [31:0] dat_i,
   input wire logic ack_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 10'h000;
      sel_o = 4'h0;
      dat_o = 32'h0000_0000;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One access; edges counts edges from launch to the ack edge
   // Blank indices are only used on purpose, by the bank scenario
   task automatic access(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                         output logic [7:0] rd, output int edges);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= {idx, 2'b00};
      sel_o <= 4'hF;
      dat_o <= {24'h00_0000, wd};
      edges = 0;
      // Bounded wait, caller judges the count
      do begin
         @(posedge clk_i);
         edges++;
      end while (ack_i !== 1'b1 && edges < 50);
      rd = dat_i[7:0];
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= 1'b0;
      // Released lines show no stale value
      adr_o <= ~adr_o;
      dat_o <= ~dat_o;
   endtask
endmodule // bus_master_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench of the banked register space
`default_nettype none
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
   $display("ERROR %0t got %h exp %h", $time, (got), (exp)); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import banked_io_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic external_reset_input = 1'b0;
   logic [7:0] p0_in = 8'h00;
   logic [7:0] p1_in = 8'h00;
   logic cyc, stb, we, ack, flag_o, xsel_o, xclk_o;
   logic [9:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat;
   logic [7:0] asc_a_o, asc_b_o;
   pin_drive_t p0_o, p1_o;
   int fail_count = 0;
   int samples_checked = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // Clock and reset
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   bus_master_model i_bus_master_model (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we),
      .adr_o(adr), .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
   banked_io_register_space i_banked_io_register_space (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
      .dat_o(rdat), .ack_o(ack), .external_reset_input_i(external_reset_input), .port0_pins_i(p0_in),
      .port1_pins_i(p1_in), .port0_pins_o(p0_o), .port1_pins_o(p1_o),
      .analog_sc_block_a_ctrl_o(asc_a_o), .analog_sc_block_b_ctrl_o(asc_b_o),
      .bank_select_flag_o(flag_o), .optional_external_clock_sel_o(xsel_o),
      .optional_external_clock_o(xclk_o));
   ////////////////////////////////////////////////////////////////////////////////
   // Verdict, also reached by a bus hang
   task automatic give_verdict();
      if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Access plus wait-state check
   task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
      int edges;
      i_bus_master_model.access(w, idx, wd, rd, edges);
      `CHECK(edges, 2)
      if (edges >= 50) give_verdict();
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] rd;
      acc(1'b1, idx, d, rd);
   endtask
   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] rd;
      acc(1'b0, idx, 8'h00, rd);
      `CHECK(rd, exp)
   endtask
   // Let the write land on the outputs, look off the edge
   task automatic settle();
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Reset values and driven programming pins
   task automatic t_reset();
      rd_chk(8'h03, 8'hFF);
      rd_chk(8'h07, 8'hFC);
      `CHECK(p1_o.oe_n, 8'hFC)
      `CHECK(p0_o.oe_n, 8'hFF)
   endtask
   // Storage registers and analog controls
   task automatic t_storage();
      logic [7:0] ids [4] = '{8'h01, 8'h02, 8'h05, 8'h06};
      foreach (ids[k]) wr(ids[k], 8'h5A ^ ids[k]);
      foreach (ids[k]) rd_chk(ids[k], 8'h5A ^ ids[k]);
      wr(8'h80, 8'hC3);
      wr(8'h84, 8'h3C);
      rd_chk(8'h84, 8'h3C);
      settle();
      `CHECK(asc_a_o, 8'hC3)
      `CHECK(asc_b_o, 8'h3C)
   endtask
   // Data register: latched bits and pin bits mixed by drive mode
   task automatic t_port();
      wr(8'h03, 8'h00);
      wr(8'h00, 8'hA5);
      settle();
      `CHECK(p0_o, 16'hA500)
      wr(8'h03, 8'hF0);
      p0_in <= 8'h3C;
      settle();
      rd_chk(8'h00, 8'h35);
      `CHECK(p0_o.oe_n, 8'hF0)
      // Port 1 data: pins 0 and 1 driven after reset, the rest read the pins
      wr(8'h04, 8'h3F);
      rd_chk(8'h04, 8'h03);
      settle();
      `CHECK(p1_o.level, 8'h3F)
   endtask
   // Bank 1: flag bit, blank places, sticky clearable status
   task automatic t_bank();
      wr(8'hF7, 8'hFF);
      settle();
      `CHECK(flag_o, 1'b1)
      rd_chk(8'hF7, 8'h01);
      rd_chk(8'h01, 8'h00);
      wr(8'h80, 8'h11);
      rd_chk(8'h80, 8'h00);
      rd_chk(8'hF9, 8'h01);
      wr(8'hF9, 8'h01);
      rd_chk(8'hF9, 8'h00);
      wr(8'hF7, 8'h00);
      rd_chk(8'h80, 8'hC3);
      rd_chk(8'h01, 8'h5B);
   endtask
   // Pin 4 of port 1 as clock input
   task automatic t_clock();
      // Drive pin 4 first, so only the clock select can release it
      wr(8'h07, 8'h00);
      wr(8'hF8, 8'h01);
      p1_in <= 8'h10;
      settle();
      `CHECK(xclk_o, 1'b1)
      `CHECK(p1_o.oe_n[4], 1'b1)
      `CHECK(xsel_o, 1'b1)
      @(posedge clk_i);
      p1_in <= 8'h00;
      settle();
      `CHECK(xclk_o, 1'b0)
      wr(8'hF8, 8'h00);
      settle();
      `CHECK(p1_o.oe_n[4], 1'b0)
      `CHECK(xsel_o, 1'b0)
   endtask
   // External reset clears registers, not the bus
   task automatic t_external_reset_input();
      @(posedge clk_i);
      external_reset_input <= 1'b1;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      `CHECK(asc_a_o, 8'h00)
      `CHECK(p1_o.oe_n, 8'hFC)
      @(posedge clk_i);
      external_reset_input <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd_chk(8'h80, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_storage();
      t_port();
      t_bank();
      t_clock();
      t_external_reset_input();
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
